// File: ramp_limiter_map.vh
/*
 * ramp_limiter_map.vh
 * register offsets, field positions, reset values and timing constants
 * for the acoustic pwm ramp limiter.
 * assumes it is included by bare name from the design files.
 */
`ifndef RAMP_LIMITER_MAP_VH
`define RAMP_LIMITER_MAP_VH

// register byte addresses
`define ADDR_PWM1_CHANNEL_CONFIG 8'h5C
`define ADDR_PWM2_CHANNEL_CONFIG 8'h5D
`define ADDR_PWM3_CHANNEL_CONFIG 8'h5E
`define ADDR_RAMP_LIMIT_CTRL_FIRST 8'h62
`define ADDR_RAMP_LIMIT_CTRL_SECOND 8'h63

// reset values
`define RST_PWM_CHANNEL_CONFIG 8'h00
`define RST_RAMP_LIMIT_CTRL 8'h00

// field positions
`define CFG_SLOW_BIT 3
`define CTRL1_CH1_SEL_HI 2
`define CTRL1_CH1_SEL_LO 0
`define CTRL1_CH1_EN_BIT 3
`define CTRL2_CH2_SEL_HI 6
`define CTRL2_CH2_SEL_LO 4
`define CTRL2_CH2_EN_BIT 7
`define CTRL2_CH3_SEL_HI 2
`define CTRL2_CH3_SEL_LO 0
`define CTRL2_CH3_EN_BIT 3

// step sizes in time slots for selector codes 000..111
`define STEP_CODE0 8'h01
`define STEP_CODE1 8'h02
`define STEP_CODE2 8'h03
`define STEP_CODE3 8'h05
`define STEP_CODE4 8'h08
`define STEP_CODE5 8'h0C
`define STEP_CODE6 8'h18
`define STEP_CODE7 8'h30

// full scale duty, 255 slots per period
`define DUTY_FULL_SCALE 8'hFF

// slow setting stretches the ramp by this many updates per step
`define SLOW_FACTOR 4
`define SLOW_CNT_MAX 2'h3

`endif

// File: ramp_step_table.v
/*
 * ramp_step_table.v
 * maps a 3-bit ramp selector to its step size in time slots.
 * assumes pure combinational use inside the ramp limiter.
 */
`timescale 1ns/100ps
`include "ramp_limiter_map.vh"

module ramp_step_table (
    input wire [2:0] i_sel,    // ramp selector code
    output reg [7:0] o_step    // step size in time slots
);

    // fixed lookup table of step sizes
    always @* begin
        case (i_sel)
            3'h0: o_step = `STEP_CODE0; // RQ1 RQ10
            3'h1: o_step = `STEP_CODE1;
            3'h2: o_step = `STEP_CODE2;
            3'h3: o_step = `STEP_CODE3;
            3'h4: o_step = `STEP_CODE4;
            3'h5: o_step = `STEP_CODE5;
            3'h6: o_step = `STEP_CODE6;
            3'h7: o_step = `STEP_CODE7;
            default: o_step = `STEP_CODE0;
        endcase
    end

endmodule

// File: ramp_channel.v
/*
 * ramp_channel.v
 * one channel of the duty slew limiter: holds the previous output duty
 * and moves it toward the target by one step per duty update.
 * assumes i_update is a one-cycle strobe from the fan control loop.
 */
`timescale 1ns/100ps
`include "ramp_limiter_map.vh"

module ramp_channel (
    input wire i_core_clk,     // core clock
    input wire i_arst_n,       // async reset, active low
    input wire i_update,       // new target duty available
    input wire [7:0] i_target, // newly calculated duty
    input wire i_enable,       // ramp limiting enabled
    input wire i_slow,         // stretch ramp by four
    input wire [7:0] i_step,   // step size in time slots
    output reg [7:0] o_duty    // limited output duty
);

    reg [1:0] slow_cnt;
    reg [7:0] next_duty;
    wire [7:0] diff_up;
    wire [7:0] diff_dn;
    wire step_now;

    assign diff_up = i_target - o_duty;
    assign diff_dn = o_duty - i_target;
    // slow mode steps only on every fourth update
    assign step_now = !i_slow || (slow_cnt == `SLOW_CNT_MAX); // RQ9 RQ11

    // next duty: follow directly, or step without overshoot
    always @* begin
        next_duty = o_duty;
        if (!i_enable) begin
            next_duty = i_target; // RQ12
        end else if (step_now) begin
            if (i_target > o_duty) begin
                // clamp keeps result at target and inside 0..255
                if (diff_up <= i_step) begin
                    next_duty = i_target; // RQ15
                end else begin
                    next_duty = o_duty + i_step; // RQ6 RQ5
                end
            end else if (i_target < o_duty) begin
                if (diff_dn <= i_step) begin
                    next_duty = i_target; // RQ15
                end else begin
                    next_duty = o_duty - i_step; // RQ7
                end
            end
        end
    end

    // duty and slow divider update only on a duty update strobe
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_duty <= 8'h00;
            slow_cnt <= 2'h0;
        end else if (i_update) begin
            o_duty <= next_duty; // RQ8 RQ16
            if (!i_enable || !i_slow) begin
                slow_cnt <= 2'h0;
            end else begin
                slow_cnt <= slow_cnt + 2'h1;
            end
        end
    end

endmodule

// File: acoustic_pwm_ramp_limiter.v
/*
 * acoustic_pwm_ramp_limiter.v
 * three-channel duty slew limiter placed after the automatic fan
 * control loop, with its byte configuration registers.
 * assumes a simple synchronous byte register port and a one-cycle
 * update strobe per channel from the fan control loop.
 */
`timescale 1ns/100ps
`include "ramp_limiter_map.vh"

// Behaviour
// RQ1 - codes 000..111 give 1,2,3,5,8,12,24,48 slots
// RQ2 - channel one selector in first control bits 2:0
// RQ3 - second register: ch2 bits 6:4, ch3 2:0
// RQ4 - per-channel enables at bits 3, 7, 3
// RQ5 - period has 255 slots, one slot increments
// RQ6 - target above previous: raise by step
// RQ7 - target below previous: lower by step
// RQ8 - adjusted duty becomes previous for next compare
// RQ9 - config bit 3 slows ramp fourfold
// RQ10 - one slot full ramp about 35 seconds
// RQ11 - slow ramp 140 down to 3.2 seconds
// RQ12 - disabled channel follows target immediately
// RQ13 - limiting acts on duty, not temperature
// RQ14 - each channel enters ramp mode independently
// RQ15 - no overshoot, clamp to target, stay 0..255
// RQ16 - one step per duty update from loop
module acoustic_pwm_ramp_limiter (
    input wire i_core_clk,         // core clock, 100 MHz
    input wire i_arst_n,           // async reset, active low
    input wire i_reg_wr,           // register write strobe
    input wire [7:0] i_reg_addr,   // register byte address
    input wire [7:0] i_reg_wdata,  // register write data
    output reg [7:0] o_reg_rdata,  // register read data
    input wire i_ch1_update,       // channel 1 new duty strobe
    input wire i_ch2_update,       // channel 2 new duty strobe
    input wire i_ch3_update,       // channel 3 new duty strobe
    input wire [7:0] i_ch1_target, // channel 1 calculated duty
    input wire [7:0] i_ch2_target, // channel 2 calculated duty
    input wire [7:0] i_ch3_target, // channel 3 calculated duty
    output wire [7:0] o_ch1_duty,  // channel 1 limited duty
    output wire [7:0] o_ch2_duty,  // channel 2 limited duty
    output wire [7:0] o_ch3_duty   // channel 3 limited duty
);

    reg [7:0] pwm1_channel_config;
    reg [7:0] pwm2_channel_config;
    reg [7:0] pwm3_channel_config;
    reg [7:0] ramp_limit_ctrl_first;
    reg [7:0] ramp_limit_ctrl_second;
    wire [2:0] ch1_ramp_select;
    wire [2:0] ch2_ramp_select;
    wire [2:0] ch3_ramp_select;
    wire [7:0] ch1_step;
    wire [7:0] ch2_step;
    wire [7:0] ch3_step;

    // field extraction from the control registers
    assign ch1_ramp_select = ramp_limit_ctrl_first[`CTRL1_CH1_SEL_HI:`CTRL1_CH1_SEL_LO]; // RQ2
    assign ch2_ramp_select = ramp_limit_ctrl_second[`CTRL2_CH2_SEL_HI:`CTRL2_CH2_SEL_LO]; // RQ3
    assign ch3_ramp_select = ramp_limit_ctrl_second[`CTRL2_CH3_SEL_HI:`CTRL2_CH3_SEL_LO]; // RQ3

    // register writes; unmapped addresses are ignored
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwm1_channel_config <= `RST_PWM_CHANNEL_CONFIG;
            pwm2_channel_config <= `RST_PWM_CHANNEL_CONFIG;
            pwm3_channel_config <= `RST_PWM_CHANNEL_CONFIG;
            ramp_limit_ctrl_first <= `RST_RAMP_LIMIT_CTRL;
            ramp_limit_ctrl_second <= `RST_RAMP_LIMIT_CTRL;
        end else if (i_reg_wr) begin
            case (i_reg_addr)
                `ADDR_PWM1_CHANNEL_CONFIG: pwm1_channel_config <= i_reg_wdata;
                `ADDR_PWM2_CHANNEL_CONFIG: pwm2_channel_config <= i_reg_wdata;
                `ADDR_PWM3_CHANNEL_CONFIG: pwm3_channel_config <= i_reg_wdata;
                `ADDR_RAMP_LIMIT_CTRL_FIRST: ramp_limit_ctrl_first <= i_reg_wdata;
                `ADDR_RAMP_LIMIT_CTRL_SECOND: ramp_limit_ctrl_second <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    // registered read data so the data output comes from a flop
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= 8'h00;
        end else begin
            case (i_reg_addr)
                `ADDR_PWM1_CHANNEL_CONFIG: o_reg_rdata <= pwm1_channel_config;
                `ADDR_PWM2_CHANNEL_CONFIG: o_reg_rdata <= pwm2_channel_config;
                `ADDR_PWM3_CHANNEL_CONFIG: o_reg_rdata <= pwm3_channel_config;
                `ADDR_RAMP_LIMIT_CTRL_FIRST: o_reg_rdata <= ramp_limit_ctrl_first;
                `ADDR_RAMP_LIMIT_CTRL_SECOND: o_reg_rdata <= ramp_limit_ctrl_second;
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // step lookup per channel
    ramp_step_table u_step1 (
        .i_sel(ch1_ramp_select),
        .o_step(ch1_step)
    );
    ramp_step_table u_step2 (
        .i_sel(ch2_ramp_select),
        .o_step(ch2_step)
    );
    ramp_step_table u_step3 (
        .i_sel(ch3_ramp_select),
        .o_step(ch3_step)
    );

    // independent limiter per channel acting on duty, so channels on one
    // temperature source still ramp at their own rates
    ramp_channel u_ch1 ( // RQ13 RQ14
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_update(i_ch1_update),
        .i_target(i_ch1_target),
        .i_enable(ramp_limit_ctrl_first[`CTRL1_CH1_EN_BIT]), // RQ4
        .i_slow(pwm1_channel_config[`CFG_SLOW_BIT]), // RQ9
        .i_step(ch1_step),
        .o_duty(o_ch1_duty)
    );
    ramp_channel u_ch2 (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_update(i_ch2_update),
        .i_target(i_ch2_target),
        .i_enable(ramp_limit_ctrl_second[`CTRL2_CH2_EN_BIT]), // RQ4
        .i_slow(pwm2_channel_config[`CFG_SLOW_BIT]),
        .i_step(ch2_step),
        .o_duty(o_ch2_duty)
    );
    ramp_channel u_ch3 (
        .i_core_clk(i_core_clk),
        .i_arst_n(i_arst_n),
        .i_update(i_ch3_update),
        .i_target(i_ch3_target),
        .i_enable(ramp_limit_ctrl_second[`CTRL2_CH3_EN_BIT]), // RQ4
        .i_slow(pwm3_channel_config[`CFG_SLOW_BIT]),
        .i_step(ch3_step),
        .o_duty(o_ch3_duty)
    );

    // ramp times (RQ10, RQ11) follow from the loop's update spacing:
    // 255 slots at one slot per update, four times longer when slow
endmodule

// File: acoustic_pwm_ramp_limiter_properties.sv
/* port checker for the ramp limiter.
   assumes a bind onto the top module, one clock domain. */
`timescale 1ns/100ps
module ramp_limiter_checker (
    input wire i_core_clk, // clock
    input wire i_arst_n, // reset
    input wire i_reg_wr, // write
    input wire [7:0] i_reg_addr, // address
    input wire [7:0] i_reg_wdata, // wdata
    input wire [7:0] o_reg_rdata, // rdata
    input wire i_ch1_update, // strobe 1
    input wire i_ch2_update, // strobe 2
    input wire i_ch3_update, // strobe 3
    input wire [7:0] i_ch1_target, // target 1
    input wire [7:0] i_ch2_target, // target 2
    input wire [7:0] i_ch3_target, // target 3
    input wire [7:0] o_ch1_duty, // duty 1
    input wire [7:0] o_ch2_duty, // duty 2
    input wire [7:0] o_ch3_duty // duty 3
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    localparam [63:0] STEPS = 64'h30180C0805030201;
    reg [7:0] ctl1;
    reg [7:0] ctl2;
    reg [7:0] cfg1;
    wire [7:0] stp = STEPS[ctl1[2:0]*8 +: 8];
    wire [7:0] t = i_ch1_target;
    wire [7:0] d = o_ch1_duty;
    wire [7:0] nxt1 = (t > d) ? ((t - d <= stp) ? t : d + stp) : ((d - t <= stp) ? t : d - stp);
    wire mapped = i_reg_addr == 8'h5C || i_reg_addr == 8'h5D || i_reg_addr == 8'h5E
        || i_reg_addr == 8'h62 || i_reg_addr == 8'h63;
    // shadow of the control bytes, so duty checks know the mode
    always @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctl1 <= 8'h00;
            ctl2 <= 8'h00;
            cfg1 <= 8'h00;
        end else if (i_reg_wr) begin
            if (i_reg_addr == 8'h62) ctl1 <= i_reg_wdata;
            if (i_reg_addr == 8'h63) ctl2 <= i_reg_wdata;
            if (i_reg_addr == 8'h5C) cfg1 <= i_reg_wdata;
        end
    end
    unmapped_read_a: assert property (!$past(mapped) |-> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    // read data is registered, so a write shows two edges later with the address held
    write_readback_a: assert property (i_reg_wr && mapped ##1 $stable(i_reg_addr) && !i_reg_wr
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("readback differs");
    ch1_hold_a: assert property (!i_ch1_update |=> $stable(o_ch1_duty))
        else $error("duty 1 moved");
    ch2_hold_a: assert property (!i_ch2_update |=> $stable(o_ch2_duty))
        else $error("duty 2 moved");
    ch3_hold_a: assert property (!i_ch3_update |=> $stable(o_ch3_duty))
        else $error("duty 3 moved");
    ch1_exact_step_a: assert property (i_ch1_update && ctl1[3] && !cfg1[3] |=> d == $past(nxt1))
        else $error("duty 1 step wrong");
    ch1_follow_a: assert property (i_ch1_update && !ctl1[3] |=> d == $past(t))
        else $error("duty 1 not following");
    ch3_follow_a: assert property (i_ch3_update && !ctl2[3] |=> o_ch3_duty == $past(i_ch3_target))
        else $error("duty 3 not following");
    ch2_toward_a: assert property (i_ch2_update |=>
        (o_ch2_duty >= $past(o_ch2_duty) && o_ch2_duty <= $past(i_ch2_target)) ||
        (o_ch2_duty <= $past(o_ch2_duty) && o_ch2_duty >= $past(i_ch2_target)))
        else $error("duty 2 overshoot");
    cover property (i_ch1_update && ctl1[3] && cfg1[3]);
    cover property (i_ch2_update && ctl2[7]);
    cover property (i_reg_wr && !mapped);
endmodule
bind acoustic_pwm_ramp_limiter ramp_limiter_checker chk (.*);

// File: fan_loop_model.sv
/* stand-in for the automatic fan loop: hands new target duties over
   with one-cycle strobes. assumes the bench clock. */
`timescale 1ns/100ps
module fan_loop_model (
    input wire i_core_clk, // core clock
    output reg [2:0] o_update, // strobes, bit 0 is channel 1
    output reg [7:0] o_tgt1, // target 1
    output reg [7:0] o_tgt2, // target 2
    output reg [7:0] o_tgt3 // target 3
);
    initial begin
        o_update = 3'h0;
        o_tgt1 = 8'h00;
        o_tgt2 = 8'h00;
        o_tgt3 = 8'h00;
    end
    // one value per strobe; targets are scrambled afterwards so that a
    // late sample in the limiter shows up as a wrong duty
    task send(input [2:0] m, input [7:0] v);
        begin
            @(posedge i_core_clk);
            o_update <= m;
            o_tgt1 <= v;
            o_tgt2 <= v;
            o_tgt3 <= v;
            @(posedge i_core_clk);
            o_update <= 3'h0;
            o_tgt1 <= ~v;
            o_tgt2 <= ~v;
            o_tgt3 <= ~v;
            #1;
        end
    endtask
endmodule

// File: tb_acoustic_pwm_ramp_limiter.sv
/* self-checking bench for the ramp limiter.
   assumes the fan loop model and the bound checker. */
`timescale 1ns/100ps
module tb_acoustic_pwm_ramp_limiter;
    reg i_core_clk = 1'b0;
    reg i_arst_n = 1'b0;
    reg wr = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata, d1, d2, d3, t1, t2, t3;
    wire [2:0] upd;
    integer errors = 0;
    integer checked = 0;
    integer k;
    localparam [63:0] STEPS = 64'h30180C0805030201;
    localparam [47:0] ADRS = 48'h605E5D5C6362;
    always #5 i_core_clk = ~i_core_clk;
    fan_loop_model src (.i_core_clk(i_core_clk), .o_update(upd), .o_tgt1(t1), .o_tgt2(t2),
        .o_tgt3(t3));
    acoustic_pwm_ramp_limiter dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_ch1_update(upd[0]), .i_ch2_update(upd[1]), .i_ch3_update(upd[2]),
        .i_ch1_target(t1), .i_ch2_target(t2), .i_ch3_target(t3),
        .o_ch1_duty(d1), .o_ch2_duty(d2), .o_ch3_duty(d3));
    task check(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] v);
        begin
            @(posedge i_core_clk);
            wr <= 1'b1;
            addr <= a;
            wdata <= v;
            @(posedge i_core_clk);
            wr <= 1'b0;
        end
    endtask
    // address held two edges so the registered read data has settled
    task rreg(input [7:0] a, input [7:0] exp);
        begin
            @(posedge i_core_clk);
            addr <= a;
            repeat (2) @(posedge i_core_clk);
            #1;
            check(rdata, exp);
        end
    endtask
    task complete_run;
        begin
            $display("checked %0d errors %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        errors = errors + 1;
        complete_run;
    end
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        for (k = 0; k < 6; k = k + 1) rreg(ADRS[k*8 +: 8], 8'h00);
        for (k = 0; k < 6; k = k + 1) wreg(ADRS[k*8 +: 8], 8'hA5 ^ k[7:0]);
        for (k = 0; k < 6; k = k + 1) rreg(ADRS[k*8 +: 8], k == 5 ? 8'h00 : 8'hA5 ^ k[7:0]);
        for (k = 0; k < 6; k = k + 1) wreg(ADRS[k*8 +: 8], 8'h00);
        $display("test registers done");
        src.send(3'h7, 8'hC8);
        check(d1, 8'hC8);
        check(d3, 8'hC8);
        src.send(3'h7, 8'h00);
        check(d2, 8'h00);
        $display("test follow done");
        // every selector code: up, up again, then down
        for (k = 0; k < 8; k = k + 1) begin
            wreg(8'h62, 8'h00);
            src.send(3'h1, 8'h00);
            wreg(8'h62, 8'h08 | k[7:0]);
            src.send(3'h1, 8'hFF);
            check(d1, STEPS[k*8 +: 8]);
            src.send(3'h1, 8'hFF);
            check(d1, 2 * STEPS[k*8 +: 8]);
            src.send(3'h1, 8'h00);
            check(d1, STEPS[k*8 +: 8]);
        end
        $display("test step table done");
        wreg(8'h62, 8'h00);
        src.send(3'h1, 8'h00);
        wreg(8'h62, 8'h0C);
        src.send(3'h1, 8'h14);
        check(d1, 8'h08);
        src.send(3'h1, 8'h14);
        check(d1, 8'h10);
        src.send(3'h1, 8'h14);
        check(d1, 8'h14);
        $display("test clamp done");
        wreg(8'h63, 8'hF8);
        src.send(3'h6, 8'h64);
        check(d2, 8'h30);
        check(d3, 8'h01);
        check(d1, 8'h14);
        wreg(8'h63, 8'hF0);
        src.send(3'h6, 8'h64);
        check(d2, 8'h60);
        check(d3, 8'h64);
        $display("test independence done");
        // slow ramp on channels 1 and 2: three updates hold, the fourth steps; disabled channel 3 follows
        wreg(8'h5C, 8'h08);
        wreg(8'h5D, 8'h08);
        wreg(8'h5E, 8'h08);
        for (k = 1; k < 5; k = k + 1) begin
            src.send(3'h7, 8'h00);
            check(d1, k < 4 ? 8'h14 : 8'h0C);
            check(d2, k < 4 ? 8'h60 : 8'h30);
            check(d3, 8'h00);
        end
        $display("test slow done");
        complete_run;
    end
endmodule
